/* bench/spi_host.sv */
`default_nettype none
module spi_host (
	input  wire logic clk_in,
	input  wire logic so_in,
	input  wire logic so_oe_in,
	output var  logic cs_n_out,
	output var  logic sck_out,
	output var  logic si_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Mode 0, link clock still between frames
	task automatic start();
		tick(1);
		cs_n_out = 1'b0;
		tick(4);
	endtask
	task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_out = tx[i];
			tick(4);
			rx[i] = so_oe_in ? so_in : 1'bx;
			sck_out = 1'b1;
			tick(4);
			sck_out = 1'b0;
		end
	endtask
	// Select rises in the low time after the last bit
	task automatic stop();
		tick(2);
		cs_n_out = 1'b1;
		si_out = ~si_out;
		tick(8);
	endtask
endmodule // spi_host
`default_nettype wire

/* bench/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WCYC = 400;
	logic       clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       wp_n_in = 1'b1;
	logic       large_part = 1'b1;
	logic       cs_n, sck, si, so_out, so_oe_out, busy_out, write_enable_out;
	int         err_total = 0;
	int         compares = 0;
	logic [31:0] seed = 32'hDEF4;
	logic [7:0] mem [int];
	logic [7:0] st_nv = 8'h00;
	logic       wel_m = 1'b0;
	logic       busy_m = 1'b0;
	logic [7:0] rx;
	always #4 clk_in = ~clk_in;
	spi_flash_program_protect #(.WRITE_CYCLES(WCYC)) uut (
		.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
		.wp_n_in(wp_n_in), .large_part_in(large_part), .so_out(so_out), .so_oe_out(so_oe_out),
		.busy_out(busy_out), .write_enable_out(write_enable_out));
	spi_host host (.clk_in(clk_in), .so_in(so_out), .so_oe_in(so_oe_out),
		.cs_n_out(cs_n), .sck_out(sck), .si_out(si));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] op(input logic [7:0] c);
		return c | (rnd() & 8'h08);
	endfunction
	function automatic logic [7:0] at(input int a);
		int m;
		m = a & (large_part ? 32'h1FFFF : 32'h0FFFF);
		return mem.exists(m) ? mem[m] : flash_pkg::ERASED;
	endfunction
	function automatic bit locked(input int a);
		if (!large_part) return st_nv[3:2] == 2'h3;
		case (st_nv[3:2])
			2'h1: return a >= 32'h18000;
			2'h2: return a >= 32'h10000;
			2'h3: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic addr(input int a);
		for (int b = 2; b >= 0; b--) host.xb(8'(a >> (8 * b)), rx);
	endtask
	task automatic idle();
		for (int n = 0; n < 1000 && busy_out !== 1'b0; n++) host.tick(1);
		if (busy_m) wel_m = 1'b0;
		busy_m = 1'b0;
		chk("busy", {7'h00, busy_out}, 8'h00);
		chk("latch", {7'h00, write_enable_out}, {7'h00, wel_m});
	endtask
	task automatic set_write_enable_cmd();
		host.start();
		host.xb(op(flash_pkg::OP_SET_WRITE_ENABLE), rx);
		host.stop();
		if (!busy_m) wel_m = 1'b1;
		chk("latch", {7'h00, write_enable_out}, {7'h00, wel_m});
	endtask
	task automatic st_rd();
		logic [7:0] e;
		e = busy_m ? 8'hFF : st_nv | {6'h00, wel_m, 1'b0};
		host.start();
		host.xb(op(flash_pkg::OP_STATUS_READ), rx);
		repeat (2) begin
			host.xb(rnd(), rx);
			chk("status", rx, e);
		end
		host.stop();
	endtask
	task automatic st_wr(input logic [7:0] v);
		bit ok;
		ok = wel_m && !busy_m && !(wp_n_in == 1'b0 && st_nv[7]);
		host.start();
		host.xb(op(flash_pkg::OP_STATUS_WRITE), rx);
		host.xb(v, rx);
		host.stop();
		chk("busy", {7'h00, busy_out}, {7'h00, ok});
		busy_m = ok;
		if (ok) st_nv = v & 8'h8C;
		idle();
	endtask
	// Bytes past the page end wrap inside it and overwrite earlier ones
	task automatic prog(input int a, input int n, input bit hold);
		logic [7:0] d;
		int b;
		bit ok;
		b = a & (large_part ? 32'h1FFFF : 32'h0FFFF);
		ok = wel_m && !busy_m && !locked(b) && n > 0;
		host.start();
		host.xb(op(flash_pkg::OP_PROGRAM), rx);
		addr(a);
		for (int i = 0; i < n; i++) begin
			d = rnd();
			host.xb(d, rx);
			if (ok) mem[(b & 32'h1FF00) | ((b + i) & 32'hFF)] = d;
		end
		host.stop();
		chk("busy", {7'h00, busy_out}, {7'h00, ok});
		busy_m = ok;
		if (!hold) idle();
	endtask
	task automatic rd(input int a, input int n);
		host.start();
		host.xb(op(flash_pkg::OP_READ), rx);
		addr(a);
		for (int i = 0; i < n; i++) begin
			host.xb(rnd(), rx);
			chk("read", rx, at(a + i));
		end
		host.stop();
	endtask
	initial begin
		repeat (80000) @(posedge clk_in);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		host.tick(4);
		chk("oe", {7'h00, so_oe_out}, 8'h00);
		chk("latch", {7'h00, write_enable_out}, 8'h00);
		st_rd();
		prog(32'h100, 2, 1'b0);
		set_write_enable_cmd();
		prog(32'hFE0000, 1, 1'b0);
		set_write_enable_cmd();
		prog(32'h1FE, 5, 1'b1);
		set_write_enable_cmd();
		st_rd();
		idle();
		rd(32'hFFFFFF, 3);
		rd(32'h100, 1);
		rd(32'h1FC, 8);
		set_write_enable_cmd();
		prog(32'h310, 258, 1'b0);
		rd(32'h30E, 6);
		set_write_enable_cmd();
		st_wr(8'hFF);
		st_rd();
		set_write_enable_cmd();
		prog(32'h400, 1, 1'b0);
		wp_n_in = 1'b0;
		st_wr(8'h04);
		st_rd();
		wp_n_in = 1'b1;
		st_wr(8'h04);
		set_write_enable_cmd();
		prog(32'h18000, 1, 1'b0);
		prog(32'h17F00, 1, 1'b0);
		wp_n_in = 1'b0;
		set_write_enable_cmd();
		st_wr(8'h88);
		set_write_enable_cmd();
		prog(32'h10000, 1, 1'b0);
		prog(32'hFF00, 2, 1'b0);
		set_write_enable_cmd();
		st_wr(8'h00);
		wp_n_in = 1'b1;
		st_rd();
		rd(32'hFEFF, 3);
		rd(32'h17FFF, 2);
		rd(32'h3FF, 2);
		// Small part: only level 11 locks, 16-bit addresses
		large_part = 1'b0;
		host.tick(4);
		set_write_enable_cmd();
		prog(32'hC000, 2, 1'b0);
		rd(32'hBFFF, 3);
		rd(32'hFFFE, 2);
		set_write_enable_cmd();
		st_wr(8'h0C);
		set_write_enable_cmd();
		prog(32'h2000, 1, 1'b0);
		rd(32'h2000, 1);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

/* inc/flash_pkg.sv */
// Overview of operation
// - Level bits lock none, top quarter, top half or all; small part only 11.
// - Hardware protection active only when protect pin low and enable bit 1.
// - Hardware protection refuses status writes; locked sectors refuse writes with or without it.
// - Writes need latch set and unlocked target; status needs latch, no protection.
// - Enable bit cannot return to 0 while protect pin stays low.
// - Status write needs latch; device then self-times update of three bits.
// - While busy, every command except status read is ignored.
// - Status write completion clears the write-enable latch.
// - Read: command and address in, then byte out MSB first, input ignored.
// - Read address increments while selected; large part wraps top to zero.
// - Program needs latch set and target outside locked region.
// - Program starts on select rising just after the last data bit.
// - Status bit 0 reads 1 during a program cycle, 0 after.
// - Program writes 1 to 256 bytes in one page, wrapping inside it.
// - Unsupplied page bytes stay; extra bytes overwrite wrapped positions.
// - Program completion clears the write-enable latch.
// - Write command without latch is ignored until select rises.
// - Opcodes are eight bits with bit 3 ignored.
// - All command, address and data bytes travel MSB first.
// - Status bit 1 shows the write-enable latch.
`default_nettype none
package flash_pkg;
	localparam int CLK_MHZ = 125;
	localparam int WRITE_TIME_US = 10000;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 21;
	localparam int MEM_BYTES = 131072;
	localparam int PAGE_BYTES = 256;
	localparam logic [7:0] OP_MASK = 8'hF7;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_SET_WRITE_ENABLE = 8'h06;
	localparam logic [1:0] LEVEL_QUARTER = 2'h1;
	localparam logic [1:0] LEVEL_HALF = 2'h2;
	localparam logic [1:0] LEVEL_ALL = 2'h3;
	localparam logic [16:0] LOCK_QUARTER_BASE = 17'h18000;
	localparam logic [16:0] LOCK_HALF_BASE = 17'h10000;
	localparam logic [16:0] LARGE_MASK = 17'h1FFFF;
	localparam logic [16:0] SMALL_MASK = 17'h0FFFF;
	localparam int ST_HW_EN = 7;
	localparam int ST_LEVEL_HI = 3;
	localparam int ST_LEVEL_LO = 2;
	localparam int ST_WEL = 1;
	localparam int ST_BUSY = 0;
	localparam logic [7:0] STATUS_BUSY = 8'hFF;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [2:0] STATUS_RESET = 3'h0;
	localparam logic [4:0] SYNC_RESET = 5'h09;
	typedef enum logic [3:0] {
		st_idle,
		st_cmd,
		st_addr,
		st_read,
		st_stat_rd,
		st_stat_wr,
		st_prog,
		st_set_write_enable_cmd,
		st_ignore
	} state_type;
endpackage
`default_nettype wire

/* logic/spi_flash_program_protect.sv */
`default_nettype none
module spi_flash_program_protect #(
	parameter int WRITE_CYCLES = flash_pkg::WRITE_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic cs_n_in,
	input  wire logic sck_in,
	input  wire logic si_in,
	input  wire logic wp_n_in,
	input  wire logic large_part_in,
	output var  logic so_out,
	output var  logic so_oe_out,
	output var  logic busy_out,
	output var  logic write_enable_out
);
	localparam int TW = flash_pkg::TIMER_W;

	logic [4:0]                sync_w;
	logic                      cs_s;
	logic                      sck_s;
	logic                      si_s;
	logic                      wp_s;
	logic                      large_s;
	logic                      cs_rise;
	logic                      cs_fall;
	logic                      sck_rise;
	logic                      byte_done;
	logic [7:0]                byte_w;
	logic [7:0]                op_w;
	logic [16:0]               addr_mask;
	logic [16:0]               addr_n;
	logic [16:0]               addr_inc;
	logic [7:0]                status_byte;
	logic [7:0]                rd_byte;
	logic                      hw_prot;
	logic                      prog_locked;
	logic                      prog_commit;
	logic                      buf_we;
	flash_pkg::state_type      state_q;
	flash_pkg::state_type      state_d;
	logic [2:0]                bit_q;
	logic [2:0]                bit_d;
	logic [7:0]                shift_q;
	logic [7:0]                shift_d;
	logic [1:0]                abyte_q;
	logic [1:0]                abyte_d;
	logic [16:0]               addr_q;
	logic [16:0]               addr_d;
	logic [7:0]                out_q;
	logic [7:0]                out_d;
	logic                      so_q;
	logic                      so_d;
	logic                      so_oe_q;
	logic                      so_oe_d;
	logic                      wel_q;
	logic                      wel_d;
	logic                      busy_q;
	logic                      busy_d;
	logic                      kind_q;
	logic                      kind_d;
	logic [TW-1:0]             timer_q;
	logic [TW-1:0]             timer_d;
	logic                      hw_protect_enable_bit_q;
	logic                      hw_protect_enable_bit_d;
	logic [1:0]                bp_q;
	logic [1:0]                bp_d;
	logic [2:0]                newst_q;
	logic [2:0]                newst_d;
	logic                      stat_got_q;
	logic                      stat_got_d;
	logic                      rd_q;
	logic                      rd_d;
	logic [7:0]                off_q;
	logic [7:0]                off_d;
	logic [8:0]                page_q;
	logic [8:0]                page_d;
	logic                      any_q;
	logic                      any_d;
	logic [255:0]              pmask_q;
	logic [255:0]              pmask_d;
	logic                      load_q;
	logic                      load_d;
	logic                      sck_q;
	logic                      cs_q;
	logic [7:0]                mem [0:flash_pkg::MEM_BYTES-1];
	logic [7:0]                pbuf [0:flash_pkg::PAGE_BYTES-1];

	function automatic logic locked_f(input logic [16:0] a, input logic [1:0] lv,
			input logic big);
		logic hit;
		hit = (lv == flash_pkg::LEVEL_ALL);
		if (big && lv == flash_pkg::LEVEL_QUARTER) begin
			hit = (a >= flash_pkg::LOCK_QUARTER_BASE);
		end
		if (big && lv == flash_pkg::LEVEL_HALF) begin
			hit = (a >= flash_pkg::LOCK_HALF_BASE);
		end
		return hit;
	endfunction

	sync_2ff #(
		.WIDTH     (5),
		.RESET_VAL (flash_pkg::SYNC_RESET)
	) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({large_part_in, wp_n_in, si_in, sck_in, cs_n_in}),
		.q_out  (sync_w)
	);

	assign cs_s = sync_w[0];
	assign sck_s = sync_w[1];
	assign si_s = sync_w[2];
	assign wp_s = sync_w[3];
	assign large_s = sync_w[4];
	assign cs_rise = cs_s & ~cs_q;
	assign cs_fall = ~cs_s & cs_q;
	assign sck_rise = sck_s & ~sck_q & ~cs_s;
	assign byte_done = sck_rise && (bit_q == flash_pkg::BIT_LAST);
	assign byte_w = {shift_q[6:0], si_s};
	assign op_w = byte_w & flash_pkg::OP_MASK;
	assign addr_mask = large_s ? flash_pkg::LARGE_MASK : flash_pkg::SMALL_MASK;
	assign addr_n = {addr_q[8:0], byte_w} & addr_mask;
	assign addr_inc = (addr_q + 17'h00001) & addr_mask;
	assign hw_prot = ~wp_s & hw_protect_enable_bit_q;
	assign prog_locked = locked_f({page_q, 8'h00}, bp_q, large_s);
	assign prog_commit = busy_q && kind_q && (timer_q == '0);
	assign rd_byte = mem[addr_q];

	always_comb begin
		status_byte = 8'h00;
		status_byte[flash_pkg::ST_HW_EN] = hw_protect_enable_bit_q;
		status_byte[flash_pkg::ST_LEVEL_HI] = bp_q[1];
		status_byte[flash_pkg::ST_LEVEL_LO] = bp_q[0];
		status_byte[flash_pkg::ST_WEL] = wel_q;
		if (busy_q) begin
			status_byte = flash_pkg::STATUS_BUSY;
		end
	end

	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		abyte_d = abyte_q;
		addr_d = addr_q;
		out_d = out_q;
		so_d = so_q;
		so_oe_d = so_oe_q;
		wel_d = wel_q;
		busy_d = busy_q;
		kind_d = kind_q;
		timer_d = timer_q;
		hw_protect_enable_bit_d = hw_protect_enable_bit_q;
		bp_d = bp_q;
		newst_d = newst_q;
		stat_got_d = stat_got_q;
		rd_d = rd_q;
		off_d = off_q;
		page_d = page_q;
		any_d = any_q;
		pmask_d = pmask_q;
		load_d = 1'b0;
		buf_we = 1'b0;
		// Self-timed write cycle
		if (busy_q) begin
			if (timer_q == '0) begin
				busy_d = 1'b0;
				wel_d = 1'b0;
				if (!kind_q) begin
					hw_protect_enable_bit_d = newst_q[2];
					bp_d = newst_q[1:0];
				end
			end else begin
				timer_d = timer_q - 1'b1;
			end
		end
		if (cs_rise) begin
			case (state_q)
				flash_pkg::st_set_write_enable_cmd: begin
					wel_d = 1'b1;
				end
				flash_pkg::st_stat_wr: begin
					if (stat_got_q && bit_q == 3'h0 && wel_q && !hw_prot) begin
						busy_d = 1'b1;
						kind_d = 1'b0;
						timer_d = TW'(WRITE_CYCLES - 1);
					end
				end
				flash_pkg::st_prog: begin
					if (bit_q == 3'h0 && any_q && wel_q && !prog_locked) begin
						busy_d = 1'b1;
						kind_d = 1'b1;
						timer_d = TW'(WRITE_CYCLES - 1);
					end
				end
				default: begin
				end
			endcase
		end
		if (cs_s) begin
			state_d = flash_pkg::st_idle;
			so_oe_d = 1'b0;
		end else if (cs_fall) begin
			state_d = flash_pkg::st_cmd;
			bit_d = 3'h0;
			abyte_d = 2'h0;
			stat_got_d = 1'b0;
		end else if (sck_rise) begin
			shift_d = byte_w;
			bit_d = bit_q + 3'h1;
			if ((state_q == flash_pkg::st_read || state_q == flash_pkg::st_stat_rd) &&
					!byte_done) begin
				out_d = {out_q[6:0], 1'b0};
				so_d = out_q[6];
			end
		end
		if (byte_done) begin
			case (state_q)
				flash_pkg::st_cmd: begin
					state_d = flash_pkg::st_ignore;
					if (busy_q) begin
						if (op_w == flash_pkg::OP_STATUS_READ) begin
							state_d = flash_pkg::st_stat_rd;
							load_d = 1'b1;
							so_oe_d = 1'b1;
						end
					end else begin
						case (op_w)
							flash_pkg::OP_READ: begin
								state_d = flash_pkg::st_addr;
								rd_d = 1'b1;
							end
							flash_pkg::OP_PROGRAM: begin
								if (wel_q) begin
									state_d = flash_pkg::st_addr;
								end
								rd_d = 1'b0;
							end
							flash_pkg::OP_STATUS_WRITE: begin
								if (wel_q) begin
									state_d = flash_pkg::st_stat_wr;
								end
							end
							flash_pkg::OP_STATUS_READ: begin
								state_d = flash_pkg::st_stat_rd;
								load_d = 1'b1;
								so_oe_d = 1'b1;
							end
							flash_pkg::OP_SET_WRITE_ENABLE: begin
								state_d = flash_pkg::st_set_write_enable_cmd;
							end
							default: begin
							end
						endcase
					end
				end
				flash_pkg::st_addr: begin
					addr_d = addr_n;
					abyte_d = abyte_q + 2'h1;
					if (abyte_q == flash_pkg::ADDR_LAST) begin
						if (rd_q) begin
							state_d = flash_pkg::st_read;
							load_d = 1'b1;
							so_oe_d = 1'b1;
						end else begin
							state_d = flash_pkg::st_prog;
							page_d = addr_n[16:8];
							off_d = addr_n[7:0];
							any_d = 1'b0;
							pmask_d = '0;
						end
					end
				end
				flash_pkg::st_prog: begin
					buf_we = 1'b1;
					pmask_d[off_q] = 1'b1;
					off_d = off_q + 8'h01;
					any_d = 1'b1;
				end
				flash_pkg::st_stat_wr: begin
					newst_d = {byte_w[flash_pkg::ST_HW_EN], byte_w[flash_pkg::ST_LEVEL_HI],
						byte_w[flash_pkg::ST_LEVEL_LO]};
					stat_got_d = 1'b1;
				end
				flash_pkg::st_read, flash_pkg::st_stat_rd: begin
					load_d = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// Next output byte, one cycle after its boundary
		if (load_q && !cs_s) begin
			if (state_q == flash_pkg::st_read) begin
				out_d = rd_byte;
				so_d = rd_byte[7];
				addr_d = addr_inc;
			end else if (state_q == flash_pkg::st_stat_rd) begin
				out_d = status_byte;
				so_d = status_byte[7];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= flash_pkg::st_idle;
			bit_q <= 3'h0;
			shift_q <= 8'h00;
			abyte_q <= 2'h0;
			addr_q <= 17'h00000;
			out_q <= 8'h00;
			so_q <= 1'b0;
			so_oe_q <= 1'b0;
			wel_q <= 1'b0;
			busy_q <= 1'b0;
			kind_q <= 1'b0;
			timer_q <= '0;
			hw_protect_enable_bit_q <= 1'b0;
			bp_q <= 2'h0;
			newst_q <= flash_pkg::STATUS_RESET;
			stat_got_q <= 1'b0;
			rd_q <= 1'b0;
			off_q <= 8'h00;
			page_q <= 9'h000;
			any_q <= 1'b0;
			pmask_q <= '0;
			load_q <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			abyte_q <= abyte_d;
			addr_q <= addr_d;
			out_q <= out_d;
			so_q <= so_d;
			so_oe_q <= so_oe_d;
			wel_q <= wel_d;
			busy_q <= busy_d;
			kind_q <= kind_d;
			timer_q <= timer_d;
			hw_protect_enable_bit_q <= hw_protect_enable_bit_d;
			bp_q <= bp_d;
			newst_q <= newst_d;
			stat_got_q <= stat_got_d;
			rd_q <= rd_d;
			off_q <= off_d;
			page_q <= page_d;
			any_q <= any_d;
			pmask_q <= pmask_d;
			load_q <= load_d;
			sck_q <= sck_s;
			cs_q <= cs_s;
		end
	end

	// Array starts erased; no erase command here
	initial begin
		for (int i = 0; i < flash_pkg::MEM_BYTES; i++) begin
			mem[i] = flash_pkg::ERASED;
		end
	end

	// Plain always: the array is also written by the erased-state initial
	always @(posedge clk_in) begin
		if (buf_we) begin
			pbuf[off_q] <= byte_w;
		end
		if (prog_commit) begin
			for (int i = 0; i < flash_pkg::PAGE_BYTES; i++) begin
				if (pmask_q[i]) begin
					mem[{page_q, 8'(i)}] <= pbuf[i];
				end
			end
		end
	end

	assign so_out = so_q;
	assign so_oe_out = so_oe_q;
	assign busy_out = busy_q;
	assign write_enable_out = wel_q;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	wel_clear_a: assert property ($fell(busy_q) |-> !wel_q)
		else $error("latch still set after write cycle");
	busy_needs_wel_a: assert property ($rose(busy_q) |-> $past(wel_q))
		else $error("write cycle started without latch");
	lock_refuse_a: assert property (
		(cs_rise && state_q == flash_pkg::st_prog && prog_locked) |=> !busy_q)
		else $error("locked page was programmed");
	hw_refuse_a: assert property (
		(cs_rise && state_q == flash_pkg::st_stat_wr && hw_prot) |=> !busy_q)
		else $error("status write under hardware protection");
	hw_protect_enable_bit_hold_a: assert property (
		(hw_protect_enable_bit_q && !wp_s && !(busy_q && !kind_q)) |=> hw_protect_enable_bit_q)
		else $error("enable bit cleared while pin low");
	busy_status_a: assert property (busy_q |-> status_byte == flash_pkg::STATUS_BUSY)
		else $error("busy status byte wrong");
	wen_bit_a: assert property (
		!busy_q |-> (status_byte[1] == wel_q && !status_byte[0]))
		else $error("status bits 1..0 wrong when idle");
	busy_ignore_a: assert property (
		(busy_q && byte_done && state_q == flash_pkg::st_cmd &&
		op_w != flash_pkg::OP_STATUS_READ) |=> state_q == flash_pkg::st_ignore)
		else $error("command accepted while busy");
	so_idle_a: assert property (cs_s |=> !so_oe_q)
		else $error("output driven while deselected");
	buf_fill_a: assert property (
		buf_we |=> (pmask_q[$past(off_q)] && off_q == 8'($past(off_q) + 8'h01)))
		else $error("page offset did not advance");
	read_wrap_a: assert property (
		(load_q && state_q == flash_pkg::st_read && addr_q == flash_pkg::LARGE_MASK &&
		large_s && !cs_s) |=> addr_q == 17'h00000)
		else $error("read address did not wrap");
endmodule // spi_flash_program_protect
`default_nettype wire

/* logic/sync_2ff.sv */
`default_nettype none
module sync_2ff #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] d_in,
	output var  logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = d_in;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= RESET_VAL;
			q_out  <= RESET_VAL;
		end else begin
			meta_q <= meta_d;
			q_out  <= sync_d;
		end
	end
endmodule // sync_2ff
`default_nettype wire
